/* File: wave_out_regs.vh */
`ifndef WAVE_OUT_REGS_VH
`define WAVE_OUT_REGS_VH

// Range reference source codes
`define REF_FIXED_10V 3'h0
`define REF_FIXED_5V 3'h1
`define REF_EXT_IN0 3'h2
`define REF_EXT_IN1 3'h3
`define REF_OTHER_CH 3'h4

// Range offset source codes
`define OFS_GROUND 3'h0
`define OFS_FIXED_5V 3'h1
`define OFS_EXT_IN0 3'h2
`define OFS_EXT_IN1 3'h3
`define OFS_OTHER_CH 3'h4

// Range field width per channel: 3-bit source plus 2-bit channel index
`define RANGE_SRC_W 3
`define RANGE_CH_W 2
`define RANGE_FIELD_W 5

// Timing mode codes
`define MODE_SW_TIMED 2'h0
`define MODE_HW_BUFFERED 2'h1
`define MODE_HW_DIRECT 2'h2

// Regeneration codes
`define REGEN_STANDARD 2'h0
`define REGEN_ONBOARD 2'h1
`define REGEN_NONE 2'h2

// Default start-to-run delay in timebase ticks
`define START_DELAY_DEFAULT 16'h0002

`endif

/* File: sample_fifo.v */
`include "wave_out_regs.vh"

module sample_fifo #(
    parameter WIDTH = 64,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rst_n,
    // Write side
    input wire wr_valid,
    input wire [WIDTH-1:0] wr_data,
    output wire wr_ready,
    // Read side
    input wire rd_pop,
    output wire [WIDTH-1:0] rd_data,
    output wire rd_valid,
    // Replay control
    input wire replay,
    input wire flush,
    output wire [AW:0] level
);

    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_ff;
    reg [AW-1:0] rd_ptr_ff;
    reg [AW:0] count_ff;
    reg [AW:0] loaded_ff;
    reg [AW:0] replay_idx_ff;

    wire full = (count_ff == DEPTH);
    wire do_wr = wr_valid && !full;
    wire do_rd = rd_pop && rd_valid;

    function [AW-1:0] inc_ptr;
        input [AW-1:0] p;
        begin
            inc_ptr = (p == DEPTH - 1) ? {AW{1'b0}} : p + 1'b1;
        end
    endfunction

    assign wr_ready = !full;
    assign rd_data = mem_ff[rd_ptr_ff];
    assign rd_valid = replay ? (loaded_ff != 0) : (count_ff != 0);
    assign level = count_ff;

    always @(posedge clk) begin
        if (do_wr) begin
            mem_ff[wr_ptr_ff] <= wr_data;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
            loaded_ff <= {(AW+1){1'b0}};
            replay_idx_ff <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
            loaded_ff <= {(AW+1){1'b0}};
            replay_idx_ff <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_ff <= inc_ptr(wr_ptr_ff);
            end
            if (replay) begin
                // Stored samples stay; read position wraps to the first one
                loaded_ff <= count_ff;
                if (do_rd) begin
                    if (replay_idx_ff + 1'b1 >= loaded_ff) begin // [RQ21]
                        replay_idx_ff <= {(AW+1){1'b0}};
                        rd_ptr_ff <= wr_ptr_ff - count_ff[AW-1:0];
                    end else begin
                        replay_idx_ff <= replay_idx_ff + 1'b1;
                        rd_ptr_ff <= inc_ptr(rd_ptr_ff);
                    end
                end
                if (do_wr) begin
                    count_ff <= count_ff + 1'b1;
                end
            end else begin
                replay_idx_ff <= {(AW+1){1'b0}};
                if (do_rd) begin
                    rd_ptr_ff <= inc_ptr(rd_ptr_ff);
                end
                case ({do_wr, do_rd})
                    2'b10: count_ff <= count_ff + 1'b1;
                    2'b01: count_ff <= count_ff - 1'b1;
                    default: count_ff <= count_ff;
                endcase
            end
        end
    end

endmodule

/* File: waveform_output_sequencer.v */
`include "wave_out_regs.vh"

// Behaviour
// (RQ1) Two or four channels, one shared clock
// (RQ2) Each sample clock pops one sample
// (RQ3) Per-channel reference: 10V, 5V, external, other
// (RQ4) Per-channel offset: ground, 5V, external, other
// (RQ5) Channel never its own offset
// (RQ6) Channel never its own reference
// (RQ7) Simplest variant: fixed ground offset, 10V
// (RQ8) Software timed: one update per command
// (RQ9) Hardware rate from internal or external clock
// (RQ10) Buffered: host blocks fill buffer, single pops
// (RQ11) Finite mode stops after programmed count
// (RQ12) Continuous mode runs until stop
// (RQ13) Standard regeneration accepts refills without interruption
// (RQ14) Onboard regeneration replays, rejects later writes
// (RQ15) Host ensures waveform fits the buffer
// (RQ16) Non-regeneration flags underflow, never repeats
// (RQ17) Direct mode writes host value to converters
// (RQ18) Start and pause triggers, digital or analog
// (RQ19) Pause blocks new samples, finishes current
// (RQ20) Internal clock: start delay, default two ticks
// (RQ21) Onboard replay wraps to first sample
module waveform_output_sequencer #(
    parameter NUM_CH = 4,
    parameter CODE_W = 16,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4,
    parameter COUNT_W = 32,
    parameter DIV_W = 16,
    parameter FIXED_RANGE = 0
) (
    input wire clk,
    input wire rst_n,
    // Configuration
    input wire [1:0] timing_mode,
    input wire finite_mode,
    input wire [1:0] regen_mode,
    input wire [COUNT_W-1:0] sample_count,
    input wire ext_clock_sel,
    input wire [DIV_W-1:0] clock_divisor,
    input wire [DIV_W-1:0] start_delay,
    input wire [NUM_CH*`RANGE_FIELD_W-1:0] ref_sel,
    input wire [NUM_CH*`RANGE_FIELD_W-1:0] ofs_sel,
    // Commands and triggers
    input wire arm,
    input wire stop,
    input wire sw_update,
    input wire dig_start_trig,
    input wire ana_start_trig,
    input wire trig_src_analog,
    input wire dig_pause_trig,
    input wire ana_pause_trig,
    input wire timebase_tick,
    input wire ext_sample_clk,
    // Host sample stream
    input wire host_valid,
    input wire [NUM_CH*CODE_W-1:0] host_data,
    output reg host_ready,
    // Converter side
    output reg [NUM_CH*CODE_W-1:0] dac_code,
    output reg dac_update,
    output reg [NUM_CH*`RANGE_SRC_W-1:0] ref_route,
    output reg [NUM_CH*`RANGE_CH_W-1:0] ref_route_ch,
    output reg [NUM_CH*`RANGE_SRC_W-1:0] ofs_route,
    output reg [NUM_CH*`RANGE_CH_W-1:0] ofs_route_ch,
    // Status
    output reg running,
    output reg done,
    output reg underflow
);

    localparam ST_IDLE = 4'b0001;
    localparam ST_ARMED = 4'b0010;
    localparam ST_DELAY = 4'b0100;
    localparam ST_RUN = 4'b1000;
    localparam DW = NUM_CH * CODE_W;

    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    reg [DIV_W-1:0] tick_cnt_ff;
    reg [DIV_W-1:0] nxt_tick_cnt;
    reg [COUNT_W-1:0] emitted_ff;
    reg load_done_ff;
    reg [DW-1:0] direct_ff;
    reg direct_full_ff;

    wire start_ev = trig_src_analog ? ana_start_trig : dig_start_trig; // [RQ18]
    wire pause_lv = trig_src_analog ? ana_pause_trig : dig_pause_trig; // [RQ18]
    wire buffered = (timing_mode == `MODE_HW_BUFFERED);
    wire direct = (timing_mode == `MODE_HW_DIRECT);
    wire sw_mode = (timing_mode == `MODE_SW_TIMED);
    wire onboard = buffered && (regen_mode == `REGEN_ONBOARD);
    wire run_st = (state_ff == ST_RUN);

    // Sample clock: internal divider or external edge, gated by pause
    wire int_edge = timebase_tick && (tick_cnt_ff == {DIV_W{1'b0}});
    wire raw_clk = ext_clock_sel ? ext_sample_clk : int_edge; // [RQ9]
    wire hw_edge = run_st && !sw_mode && raw_clk && !pause_lv; // [RQ19]

    wire fifo_wr_ready;
    wire [DW-1:0] fifo_rd_data;
    wire fifo_rd_valid;
    wire [FIFO_AW:0] fifo_level;
    wire fifo_pop = hw_edge && buffered && fifo_rd_valid; // [RQ2]
    wire fifo_flush = (state_ff == ST_IDLE) && arm;
    // Onboard replay: further writes refused once loading has finished
    wire fifo_wr = buffered && host_valid && !(onboard && load_done_ff); // [RQ14]
    wire last_sample = finite_mode && (emitted_ff + 1'b1 >= sample_count); // [RQ11]
    wire sample_emit = fifo_pop || (hw_edge && direct && direct_full_ff);
    // Direct slot takes a word only on a visible handshake, so the host never skips one
    wire direct_take = direct && host_valid && host_ready && !direct_full_ff; // [RQ17]
    wire direct_emit = hw_edge && direct && direct_full_ff;
    wire nxt_direct_full = direct_take || (direct_full_ff && !direct_emit);

    sample_fifo #(
        .WIDTH(DW),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .wr_valid(fifo_wr),
        .wr_data(host_data),
        .wr_ready(fifo_wr_ready),
        .rd_pop(fifo_pop),
        .rd_data(fifo_rd_data),
        .rd_valid(fifo_rd_valid),
        .replay(onboard && load_done_ff), // [RQ14]
        .flush(fifo_flush),
        .level(fifo_level)
    );

    // Legal range route: self routing falls back to the fixed default
    function [`RANGE_FIELD_W-1:0] legal_route;
        input [`RANGE_FIELD_W-1:0] sel;
        input integer ch;
        input is_ref;
        reg [`RANGE_SRC_W-1:0] src;
        reg [`RANGE_CH_W-1:0] oc;
        begin
            src = sel[`RANGE_FIELD_W-1:`RANGE_CH_W];
            oc = sel[`RANGE_CH_W-1:0];
            legal_route = sel;
            if (FIXED_RANGE != 0) begin
                legal_route = {is_ref ? `REF_FIXED_10V : `OFS_GROUND, {`RANGE_CH_W{1'b0}}};
            end else if (src > `REF_OTHER_CH) begin
                legal_route = {is_ref ? `REF_FIXED_10V : `OFS_GROUND, {`RANGE_CH_W{1'b0}}};
            end else if (src == `REF_OTHER_CH && (oc == ch[`RANGE_CH_W-1:0] || oc >= NUM_CH)) begin
                legal_route = {is_ref ? `REF_FIXED_10V : `OFS_GROUND, {`RANGE_CH_W{1'b0}}};
            end
        end
    endfunction

    integer i;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_route <= {(NUM_CH*`RANGE_SRC_W){1'b0}};
            ref_route_ch <= {(NUM_CH*`RANGE_CH_W){1'b0}};
            ofs_route <= {(NUM_CH*`RANGE_SRC_W){1'b0}};
            ofs_route_ch <= {(NUM_CH*`RANGE_CH_W){1'b0}};
        end else begin
            for (i = 0; i < NUM_CH; i = i + 1) begin
                {ref_route[i*`RANGE_SRC_W +: `RANGE_SRC_W],
                 ref_route_ch[i*`RANGE_CH_W +: `RANGE_CH_W]} <=
                    legal_route(ref_sel[i*`RANGE_FIELD_W +: `RANGE_FIELD_W], i, 1'b1); // [RQ3] [RQ6] [RQ7]
                {ofs_route[i*`RANGE_SRC_W +: `RANGE_SRC_W],
                 ofs_route_ch[i*`RANGE_CH_W +: `RANGE_CH_W]} <=
                    legal_route(ofs_sel[i*`RANGE_FIELD_W +: `RANGE_FIELD_W], i, 1'b0); // [RQ4] [RQ5] [RQ7]
            end
        end
    end

    always @* begin
        nxt_state = state_ff;
        nxt_tick_cnt = tick_cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                if (arm && !sw_mode) begin
                    nxt_state = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (stop) begin
                    nxt_state = ST_IDLE;
                end else if (start_ev) begin
                    if (ext_clock_sel) begin
                        nxt_state = ST_RUN;
                    end else begin
                        nxt_state = ST_DELAY; // [RQ20]
                        nxt_tick_cnt = start_delay;
                    end
                end
            end
            ST_DELAY: begin
                if (stop) begin
                    nxt_state = ST_IDLE;
                end else if (timebase_tick) begin
                    if (tick_cnt_ff <= 1) begin
                        // Next tick issues the first update
                        nxt_state = ST_RUN; // [RQ20]
                        nxt_tick_cnt = {DIV_W{1'b0}};
                    end else begin
                        nxt_tick_cnt = tick_cnt_ff - 1'b1;
                    end
                end
            end
            ST_RUN: begin
                if (timebase_tick) begin
                    nxt_tick_cnt = (tick_cnt_ff == {DIV_W{1'b0}}) ?
                        clock_divisor - 1'b1 : tick_cnt_ff - 1'b1;
                end
                if (stop) begin
                    nxt_state = ST_IDLE; // [RQ12]
                end else if (sample_emit && last_sample) begin
                    nxt_state = ST_IDLE; // [RQ11]
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            tick_cnt_ff <= {DIV_W{1'b0}};
            emitted_ff <= {COUNT_W{1'b0}};
            load_done_ff <= 1'b0;
            direct_ff <= {DW{1'b0}};
            direct_full_ff <= 1'b0;
            dac_code <= {DW{1'b0}};
            dac_update <= 1'b0;
            host_ready <= 1'b0;
            running <= 1'b0;
            done <= 1'b0;
            underflow <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            tick_cnt_ff <= nxt_tick_cnt;
            running <= (nxt_state == ST_RUN);
            dac_update <= 1'b0;
            // Standard regeneration keeps taking refills while running
            host_ready <= sw_mode || (direct && !nxt_direct_full) ||
                (buffered && fifo_wr_ready && !(onboard && load_done_ff)); // [RQ13] [RQ10]
            if (fifo_flush) begin
                emitted_ff <= {COUNT_W{1'b0}};
                load_done_ff <= 1'b0;
                underflow <= 1'b0;
                done <= 1'b0;
                direct_full_ff <= 1'b0;
            end
            if (onboard && start_ev && state_ff == ST_ARMED) begin
                load_done_ff <= 1'b1; // [RQ14]
            end
            if (sw_mode && sw_update && host_valid) begin
                dac_code <= host_data; // [RQ8]
                dac_update <= 1'b1; // [RQ1]
            end
            if (direct_take) begin
                direct_ff <= host_data;
                direct_full_ff <= 1'b1;
            end
            if (fifo_pop) begin
                dac_code <= fifo_rd_data; // [RQ2] [RQ1]
                dac_update <= 1'b1;
            end else if (hw_edge && direct && direct_full_ff) begin
                dac_code <= direct_ff; // [RQ17]
                dac_update <= 1'b1;
                direct_full_ff <= 1'b0;
            end else if (hw_edge && (buffered || direct) &&
                         regen_mode == `REGEN_NONE) begin
                underflow <= 1'b1; // [RQ16]
            end
            if (sample_emit) begin
                emitted_ff <= emitted_ff + 1'b1;
            end
            if (run_st && nxt_state == ST_IDLE && !stop) begin
                done <= 1'b1;
            end
        end
    end

endmodule

/* File: wave_out_chk.sv */
`include "wave_out_regs.vh"
module wave_out_chk #(
    parameter NUM_CH = 4,
    parameter CODE_W = 16
) (
    // Clock and reset
    input clk,
    input rst_n,
    // Sequencer inputs
    input [1:0] timing_mode,
    input [1:0] regen_mode,
    input sw_update,
    input trig_src_analog,
    input dig_pause_trig,
    input ana_pause_trig,
    input host_valid,
    input [NUM_CH*CODE_W-1:0] host_data,
    input [NUM_CH*5-1:0] ref_sel,
    input [NUM_CH*5-1:0] ofs_sel,
    // Sequencer outputs
    input [NUM_CH*CODE_W-1:0] dac_code,
    input dac_update,
    input [NUM_CH*3-1:0] ref_route,
    input [NUM_CH*2-1:0] ref_route_ch,
    input [NUM_CH*3-1:0] ofs_route,
    input running,
    input done,
    input underflow
);
timeunit 1ns;
timeprecision 1ns;
wire paused = trig_src_analog ? ana_pause_trig : dig_pause_trig;
wire sw_mode = timing_mode == `MODE_SW_TIMED;
wire hw_buf = timing_mode == `MODE_HW_BUFFERED;
default clocking @(posedge clk);
endclocking
default disable iff (!rst_n);
AST_SW_ONE: assert property (sw_mode && sw_update && host_valid |=>
    dac_update && dac_code == $past(host_data)) else $error("software update lost");
AST_SW_QUIET: assert property (sw_mode && $past(sw_mode) && !$past(sw_update)
    |-> !dac_update) else $error("update without command");
AST_PAUSE: assert property (hw_buf && paused && $past(paused) && $past(paused, 2)
    |-> !dac_update) else $error("update while paused");
AST_REF_SELF: assert property (ref_sel[4:0] == 5'h10
    |=> ref_route[2:0] == `REF_FIXED_10V) else $error("self reference");
AST_OFS_SELF: assert property (ofs_sel[9:5] == 5'h11
    |=> ofs_route[5:3] == `OFS_GROUND) else $error("self offset");
AST_REF_OTHER: assert property (ref_sel[4:2] == `REF_OTHER_CH && ref_sel[1:0] != 2'h0
    |=> ref_route[2:0] == `REF_OTHER_CH && ref_route_ch[1:0] == $past(ref_sel[1:0]))
    else $error("reference route lost");
AST_FIN_QUIET: assert property (hw_buf && done && $past(done) |-> !dac_update)
    else $error("update after finite end");
AST_DONE_STOP: assert property (done |-> !running) else $error("running after done");
AST_UFL_MODE: assert property ($rose(underflow) |-> $past(regen_mode) == `REGEN_NONE)
    else $error("underflow outside non-regeneration");
endmodule

bind waveform_output_sequencer wave_out_chk #(.NUM_CH(NUM_CH), .CODE_W(CODE_W)) u_chk (.*);

/* File: host_model.sv */
module host_model (
    // Clock and reset
    input clk,
    input rst_n,
    // Scenario control
    input en,
    input [7:0] limit,
    // Sample stream
    input host_ready,
    output reg host_valid,
    output reg [63:0] host_data
);
timeunit 1ns;
timeprecision 1ns;
reg [15:0] idx_ff;
wire [15:0] nxt_idx = idx_ff + {15'h0, host_valid & host_ready};
// Never offers more words than the buffer holds
wire offer = en && nxt_idx < {8'h0, limit} && limit <= 8'h10;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        idx_ff <= 16'h0;
        host_valid <= 1'h0;
        host_data <= 64'h0;
    end else begin
        idx_ff <= en ? nxt_idx : 16'h0;
        host_valid <= offer;
        // Released data lines keep changing
        host_data <= offer ? {nxt_idx + 16'h0300, nxt_idx + 16'h0200,
            nxt_idx + 16'h0100, nxt_idx} : ~host_data;
    end
end
endmodule

/* File: waveform_output_sequencer_tb.sv */
`include "wave_out_regs.vh"
module waveform_output_sequencer_tb;
timeunit 1ns;
timeprecision 1ns;
reg clk = 1'h0, rst_n = 1'h0, finite_mode = 1'h0, ext_clock_sel = 1'h0, arm = 1'h0;
reg stop = 1'h0, sw_update = 1'h0, dig_start_trig = 1'h0, ana_start_trig = 1'h0;
reg trig_src_analog = 1'h0, dig_pause_trig = 1'h0, ana_pause_trig = 1'h0, en = 1'h0;
reg timebase_tick = 1'h0, ext_sample_clk = 1'h0;
reg [1:0] timing_mode = 2'h0, regen_mode = 2'h0, tb_cnt = 2'h0;
reg [31:0] sample_count = 32'h0;
reg [19:0] ref_sel = 20'h0, ofs_sel = 20'h0;
reg [7:0] limit = 8'h0;
reg [63:0] exp;
wire [15:0] clock_divisor = 16'h0002;
wire [15:0] start_delay = `START_DELAY_DEFAULT;
wire host_valid, host_ready, dac_update, running, done, underflow;
wire [63:0] host_data, dac_code;
wire [11:0] ref_route, ofs_route;
wire [7:0] ref_route_ch, ofs_route_ch;
integer n_errors = 0, checked = 0, n_upd = 0, j, m, t, t0;
waveform_output_sequencer u_waveform_output_sequencer (.*);
host_model u_host_model (.*);
always #25 clk = ~clk;
always @(posedge clk) begin
    tb_cnt <= tb_cnt + 2'h1;
    timebase_tick <= tb_cnt[0];
    ext_sample_clk <= ext_clock_sel & (tb_cnt == 2'h3);
end
always @(negedge clk) begin
    if (dac_update === 1'h1)
        n_upd = n_upd + 1;
end
function [63:0] word(input integer k);
    word = {k[15:0] + 16'h0300, k[15:0] + 16'h0200, k[15:0] + 16'h0100, k[15:0]};
endfunction
task chk(input ok, input [8*32-1:0] msg);
    checked = checked + 1;
    if (!ok) begin
        n_errors = n_errors + 1;
        $display("MISMATCH at %0t: %0s", $time, msg);
    end
endtask
task end_of_test;
    $display("checks %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask
// Waits for the next update and counts timebase ticks meanwhile
task wait_upd;
    integer i;
    i = 0;
    t = 0;
    do begin
        @(negedge clk);
        t = t + (timebase_tick === 1'h1);
        i = i + 1;
    end while (dac_update !== 1'h1 && i < 400);
    chk(dac_update === 1'h1, "missing update");
endtask
task collect(input integer first, input integer n, input integer rep);
    for (j = first; j < first + n; j = j + 1) begin
        wait_upd;
        if (j == first)
            t0 = t;
        chk(dac_code === word(j % rep), "sample data");
    end
endtask
task run(input [1:0] tm, input [1:0] rg, input fin, input ana, input [7:0] nld, input [31:0] cnt);
    @(posedge clk);
    timing_mode <= tm;
    regen_mode <= rg;
    finite_mode <= fin;
    trig_src_analog <= ana;
    ext_clock_sel <= (rg == `REGEN_NONE);
    sample_count <= cnt;
    limit <= nld;
    repeat (2) @(posedge clk);
    arm <= 1'h1;
    @(posedge clk);
    arm <= 1'h0;
    repeat (2) @(posedge clk);
    en <= 1'h1;
    repeat (40) @(posedge clk);
    dig_start_trig <= ~ana;
    ana_start_trig <= ana;
    @(posedge clk);
    dig_start_trig <= 1'h0;
    ana_start_trig <= 1'h0;
endtask
task halt;
    @(posedge clk);
    stop <= 1'h1;
    en <= 1'h0;
    @(posedge clk);
    stop <= 1'h0;
endtask
initial begin
    repeat (20) @(posedge clk);
    chk({running, done, underflow, dac_update, host_ready} === 5'h0, "reset outputs");
    rst_n <= 1'h1;
    en <= 1'h1;
    limit <= 8'h08;
    m = n_upd;
    for (j = 0; j < 3; j = j + 1) begin
        @(posedge clk);
        sw_update <= 1'h1;
        @(negedge clk);
        exp = host_data;
        @(posedge clk);
        sw_update <= 1'h0;
        @(negedge clk);
        chk(dac_update === 1'h1 && dac_code === exp, "software update");
    end
    repeat (10) @(negedge clk);
    chk(n_upd === m + 3, "software update count");
    halt;
    // Every source code, then an unknown one
    for (j = 0; j < 6; j = j + 1) begin
        @(posedge clk);
        ref_sel <= {15'h0, j[2:0], 2'h1};
        ofs_sel <= {15'h0, j[2:0], 2'h1};
        repeat (2) @(negedge clk);
        exp = (j < 5) ? j : 0;
        chk(ref_route[2:0] === exp[2:0], "reference route");
        chk(ofs_route[2:0] === exp[2:0], "offset route");
        chk(ofs_route_ch[1:0] === ((j < 5) ? 2'h1 : 2'h0), "offset channel");
    end
    @(posedge clk);
    ref_sel <= 20'h00010;
    ofs_sel <= 20'h00220;
    repeat (2) @(negedge clk);
    chk(ref_route[2:0] === 3'h0, "self reference");
    chk(ofs_route[5:3] === 3'h0, "self offset");
    run(`MODE_HW_BUFFERED, `REGEN_STANDARD, 1'h1, 1'h0, 8'h06, 32'h6);
    collect(0, 2, 6);
    chk(t0 >= 2 && t0 <= 4, "start delay");
    @(posedge clk);
    dig_pause_trig <= 1'h1;
    repeat (3) @(negedge clk);
    m = n_upd;
    repeat (30) @(negedge clk);
    chk(n_upd === m, "update while paused");
    @(posedge clk);
    dig_pause_trig <= 1'h0;
    collect(2, 4, 6);
    repeat (20) @(negedge clk);
    chk(done === 1'h1 && running === 1'h0, "finite end");
    m = n_upd;
    repeat (40) @(negedge clk);
    chk(n_upd === m, "update after finite end");
    halt;
    // Extra words offered after start must be refused
    run(`MODE_HW_BUFFERED, `REGEN_ONBOARD, 1'h0, 1'h1, 8'h03, 32'h3);
    limit <= 8'h06;
    collect(0, 7, 3);
    chk(host_ready === 1'h0 && running === 1'h1, "replay run");
    halt;
    repeat (5) @(negedge clk);
    chk(running === 1'h0, "stop");
    run(`MODE_HW_BUFFERED, `REGEN_NONE, 1'h0, 1'h0, 8'h02, 32'h2);
    collect(0, 2, 2);
    repeat (20) @(negedge clk);
    chk(underflow === 1'h1 && dac_code === word(1), "underflow");
    halt;
    // Direct mode: each host word goes straight to the converters
    run(`MODE_HW_DIRECT, `REGEN_STANDARD, 1'h1, 1'h0, 8'h03, 32'h3);
    collect(0, 3, 3);
    repeat (10) @(negedge clk);
    chk(done === 1'h1 && underflow === 1'h0, "direct finite end");
    halt;
    end_of_test;
end
initial begin
    repeat (20000) @(posedge clk);
    n_errors = n_errors + 1;
    end_of_test;
end
endmodule
